// >>> inc/pgc_pkg.sv
// Purpose: shared constants, state types and pattern functions for the traffic generator/checker
// Assumes: four-segment packet bus, 128-bit segments, one clock for all logic
// Notes: generator and checker derive the same pattern from packet and beat numbers
package pgc_pkg;

  localparam int SEGS = 4;
  localparam int SEG_W = 128;
  localparam int CH_W = 11;
  localparam int MTY_W = 4;
  localparam int PIPE_STAGES = 3;

  // lock-setup values, also used as reset values; TX_ENABLE_ON is driven in the enable state
  localparam logic TX_ENABLE_OFF = 1'h0;
  localparam logic TX_ENABLE_ON = 1'h1;
  localparam logic [7:0] MUBITS_LOCK = 8'h00;
  localparam logic [11:0] LANESTAT_LOCK = 12'hfff;
  localparam logic INTFSTAT_LOCK = 1'h1;

  typedef enum logic [9:0] {
    st_idle       = 10'h001,
    st_lock_setup = 10'h002,
    st_wait_align = 10'h004,
    st_enable_send = 10'h008,
    st_tx_init    = 10'h010,
    st_send_first = 10'h020,
    st_send_rest  = 10'h040,
    st_hold       = 10'h080,
    st_done       = 10'h100,
    st_restart    = 10'h200
  } gen_state_t;

  typedef enum logic [8:0] {
    ck_idle          = 9'h001,
    ck_lock          = 9'h002,
    ck_wait_align    = 9'h004,
    st_enable_check  = 9'h008,
    ck_rx_init       = 9'h010,
    ck_receive       = 9'h020,
    ck_done          = 9'h040,
    st_report_result = 9'h080,
    ck_restart       = 9'h100
  } chk_state_t;

  function automatic logic [SEG_W-1:0] exp_data(input logic [7:0] pkt, input logic [7:0] beat,
                                                 input logic [1:0] seg);
    logic [7:0] b;
    b = pkt + {beat[5:0], seg};
    return {(SEG_W/8){b}};
  endfunction

  function automatic logic [CH_W-1:0] exp_chan(input logic [7:0] pkt);
    return {3'h0, pkt};
  endfunction

endpackage

// >>> inc/chk_if.sv
// Purpose: carries the receive bus and checker status between the top and the checker
// Assumes: all signals on the bus clock
// Notes: top drives the receive side and the synced run request
`timescale 1ns/1ps
`default_nettype none
interface chk_if;
  logic [pgc_pkg::SEGS-1:0] rx_ena;
  logic [pgc_pkg::SEGS-1:0] rx_sop;
  logic [pgc_pkg::SEGS-1:0] rx_eop;
  logic [pgc_pkg::SEGS-1:0][pgc_pkg::MTY_W-1:0] rx_mty;
  logic [pgc_pkg::SEGS-1:0][pgc_pkg::SEG_W-1:0] rx_data;
  logic [pgc_pkg::SEGS-1:0][pgc_pkg::CH_W-1:0] rx_chan;
  logic rx_aligned;
  logic reset_done;
  logic rerun_request_synced;
  logic checker_lock_seen;
  logic busy;
  logic done_int;
  logic report_done;
  logic failed;
  logic [pgc_pkg::SEGS-1:0] err_data;
  logic [pgc_pkg::SEGS-1:0] err_chan;
  logic err_mty;

  modport top (output rx_ena, rx_sop, rx_eop, rx_mty, rx_data, rx_chan, rx_aligned, reset_done,
               rerun_request_synced,
               input checker_lock_seen, busy, done_int, report_done, failed, err_data, err_chan,
               err_mty);
  modport chk (input rx_ena, rx_sop, rx_eop, rx_mty, rx_data, rx_chan, rx_aligned, reset_done,
               rerun_request_synced,
               output checker_lock_seen, busy, done_int, report_done, failed, err_data, err_chan,
               err_mty);
endinterface
`default_nettype wire

// >>> hw/pkt_checker.sv
// Purpose: receives the test packets and compares them against the expected pattern
// Assumes: generator sends all four segments in every beat, eop in segment 3
// Notes: error flag stays set until reset; report outputs hold until the next run
`timescale 1ns/1ps
`default_nettype none
module pkt_checker #(
  parameter int NUM_PKTS = 32,
  parameter int PKT_BEATS = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  chk_if.chk bus
);

  localparam logic [7:0] NUM_PKTS_C = 8'(NUM_PKTS);

  pgc_pkg::chk_state_t state, next_state;
  logic [7:0] pkt_cnt;
  logic [7:0] beat_cnt;
  logic enable;
  logic error_int;
  logic lock_seen;
  logic busy;
  logic done_int;
  logic report_done;
  logic failed;
  logic [pgc_pkg::SEGS-1:0] err_data;
  logic [pgc_pkg::SEGS-1:0] err_chan;
  logic err_mty;
  logic [pgc_pkg::SEGS-1:0] data_bad;
  logic [pgc_pkg::SEGS-1:0] chan_bad;
  logic [pgc_pkg::SEGS-1:0] mty_bad;

  // ----------------------------------------------------------------
  // per-segment compare
  // ----------------------------------------------------------------
  wire beat_seen = enable && (state == pgc_pkg::ck_receive) && (|bus.rx_ena);
  wire pkt_end = |(bus.rx_ena & bus.rx_eop);
  wire all_rcvd = (pkt_cnt == NUM_PKTS_C);

  genvar s;
  generate
    for (s = 0; s < pgc_pkg::SEGS; s++) begin : g_seg
      assign data_bad[s] = bus.rx_ena[s] &&
        (bus.rx_data[s] != pgc_pkg::exp_data(pkt_cnt, beat_cnt, 2'(s)));
      assign chan_bad[s] = bus.rx_ena[s] &&
        (bus.rx_chan[s] != pgc_pkg::exp_chan(pkt_cnt));
      // every beat is full, so any eop segment must report no empty bytes
      assign mty_bad[s] = bus.rx_ena[s] && bus.rx_eop[s] && (bus.rx_mty[s] != 4'h0);
    end
  endgenerate

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      pgc_pkg::ck_idle: if (bus.reset_done) next_state = pgc_pkg::ck_lock;
      pgc_pkg::ck_lock: next_state = pgc_pkg::ck_wait_align;
      pgc_pkg::ck_wait_align: if (bus.rx_aligned) next_state = pgc_pkg::st_enable_check;
      pgc_pkg::st_enable_check: next_state = pgc_pkg::ck_rx_init;
      pgc_pkg::ck_rx_init: next_state = pgc_pkg::ck_receive;
      pgc_pkg::ck_receive: if (all_rcvd) next_state = pgc_pkg::ck_done;
      pgc_pkg::ck_done: next_state = pgc_pkg::st_report_result;
      pgc_pkg::st_report_result: next_state = pgc_pkg::ck_restart;
      pgc_pkg::ck_restart: if (bus.rerun_request_synced) next_state = pgc_pkg::ck_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pgc_pkg::ck_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_cnt <= 8'h00;
      beat_cnt <= 8'h00;
      enable <= 1'h0;
      lock_seen <= 1'h0;
      busy <= 1'h0;
      done_int <= 1'h0;
      report_done <= 1'h0;
      failed <= 1'h0;
    end else begin
      unique case (state)
        pgc_pkg::ck_lock: begin
          lock_seen <= 1'h1;
          busy <= 1'h1;
          report_done <= 1'h0;
          failed <= 1'h0;
        end
        pgc_pkg::st_enable_check: enable <= 1'h1;
        pgc_pkg::ck_rx_init: begin
          pkt_cnt <= 8'h00;
          beat_cnt <= 8'h00;
          done_int <= 1'h0;
        end
        pgc_pkg::ck_receive: begin
          if (beat_seen && !all_rcvd) begin
            pkt_cnt <= pkt_end ? pkt_cnt + 8'h01 : pkt_cnt;
            beat_cnt <= pkt_end ? 8'h00 : beat_cnt + 8'h01;
          end
        end
        pgc_pkg::ck_done: done_int <= 1'h1;
        pgc_pkg::st_report_result: begin
          report_done <= 1'h1;
          failed <= error_int;
        end
        pgc_pkg::ck_restart: begin
          enable <= 1'h0;
          busy <= 1'h0;
          pkt_cnt <= 8'h00;
          beat_cnt <= 8'h00;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // error pulses and sticky flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_data <= 4'h0;
      err_chan <= 4'h0;
      err_mty <= 1'h0;
      error_int <= 1'h0;
    end else begin
      err_data <= beat_seen ? data_bad : 4'h0;
      err_chan <= beat_seen ? chan_bad : 4'h0;
      err_mty <= beat_seen && (|mty_bad);
      if (beat_seen && (|{data_bad, chan_bad, mty_bad})) error_int <= 1'h1;
    end
  end

  assign bus.checker_lock_seen = lock_seen;
  assign bus.busy = busy;
  assign bus.done_int = done_int;
  assign bus.report_done = report_done;
  assign bus.failed = failed;
  assign bus.err_data = err_data;
  assign bus.err_chan = err_chan;
  assign bus.err_mty = err_mty;

endmodule
`default_nettype wire

// >>> hw/pkt_gen_check.sv
// Purpose: self-test traffic generator with attached checker for a segmented packet bus
// Assumes: controller status and bus signals share clk; user pins are asynchronous
// Notes: a beat is taken by the controller in any cycle with tx_ena set and tx_rdy high
//
// Functional notes
// - generator idles after reset, starts lock setup once reset-complete is high
// - lock setup drives enable 0, mubits 0, lanestat all ones, intfstat 1
// - wait for receive alignment, or remote-aligned input in simplex transmit
// - enable state drives transmit enable 1, then goes to transmit init
// - transmit init clears counters, proceeds when init-complete and ready are high
// - first transmit state starts fixed-size packets, goes to done when all sent
// - second transmit state sends remaining beats, returns to first at packet end
// - ready low in a transmit state enters hold; resumes the left state
// - done state sets the transmit-done flag, then goes to restart
// - restart state clears busy and returns to idle
// - checker idles after reset, moves to lock when reset-complete is high
// - checker lock state sets lock-seen and busy, then waits for alignment
// - checker waits for alignment, sets enable, proceeds to receive init
// - receive init clears reception counters, then enters receive
// - receive compares data per segment, one data error per segment
// - one channel error per segment plus one empty-byte count error
// - any error sets a sticky flag cleared only by reset; done after all packets
// - checker done state sets receive-done flag, then reports result
// - report asserts complete and failed according to the sticky error flag
// - checker restart clears reception and busy, waits for the rerun request
// - rerun request starts a new run only while generator and checker idle
// - user inputs and status outputs pass three register stages; the rx error outputs come straight from the checker
`timescale 1ns/1ps
`default_nettype none
module pkt_gen_check #(
  parameter int NUM_PKTS = 32,
  parameter int PKT_BEATS = 4,
  parameter bit SIMPLEX_TX = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_done,
  input wire logic stat_rx_aligned,
  input wire logic rerun_in,
  input wire logic simplex_aligned_in,
  input wire logic tx_rdy,
  input wire logic tx_ovf,
  input wire logic tx_unf,
  output logic ctl_tx_enable,
  output logic [7:0] ctl_tx_mubits,
  output logic [11:0] ctl_tx_lanestat,
  output logic ctl_tx_intfstat,
  output logic [pgc_pkg::SEGS-1:0] tx_ena,
  output logic [pgc_pkg::SEGS-1:0] tx_sop,
  output logic [pgc_pkg::SEGS-1:0] tx_eop,
  output logic [pgc_pkg::SEGS*pgc_pkg::MTY_W-1:0] tx_mty,
  output logic [pgc_pkg::SEGS*pgc_pkg::SEG_W-1:0] tx_data,
  output logic [pgc_pkg::SEGS*pgc_pkg::CH_W-1:0] tx_chan,
  input wire logic [pgc_pkg::SEGS-1:0] rx_ena,
  input wire logic [pgc_pkg::SEGS-1:0] rx_sop,
  input wire logic [pgc_pkg::SEGS-1:0] rx_eop,
  input wire logic [pgc_pkg::SEGS*pgc_pkg::MTY_W-1:0] rx_mty,
  input wire logic [pgc_pkg::SEGS*pgc_pkg::SEG_W-1:0] rx_data,
  input wire logic [pgc_pkg::SEGS*pgc_pkg::CH_W-1:0] rx_chan,
  output logic tx_locked_out,
  output logic tx_done_out,
  output logic tx_fail_out,
  output logic tx_busy_out,
  output logic rx_locked_out,
  output logic rx_aligned_out,
  output logic rx_done_out,
  output logic rx_fail_out,
  output logic rx_busy_out,
  output logic [pgc_pkg::SEGS-1:0] rx_err_data,
  output logic [pgc_pkg::SEGS-1:0] rx_err_chan,
  output logic rx_err_mty
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // counters are 8 bits and the pattern uses six bits of beat number
  if (NUM_PKTS < 1 || NUM_PKTS > 255) begin : g_bad_pkts
    $error("NUM_PKTS must be 1 to 255");
  end
  if (PKT_BEATS < 1 || PKT_BEATS > 63) begin : g_bad_beats
    $error("PKT_BEATS must be 1 to 63");
  end

  localparam logic [7:0] NUM_PKTS_C = 8'(NUM_PKTS);
  localparam logic [7:0] LAST_BEAT_C = 8'(PKT_BEATS - 1);
  localparam logic SINGLE_BEAT = (PKT_BEATS == 1);
  localparam int OUT_N = 9;

  // ----------------------------------------------------------------
  // user pin stages
  // ----------------------------------------------------------------
  logic [pgc_pkg::PIPE_STAGES-1:0][1:0] in_q;
  logic [pgc_pkg::PIPE_STAGES-1:0][OUT_N-1:0] out_q;
  logic [OUT_N-1:0] status_raw;

  wire rerun_request_synced = in_q[pgc_pkg::PIPE_STAGES-1][0];
  wire remote_aligned = in_q[pgc_pkg::PIPE_STAGES-1][1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_q <= '0;
      out_q <= '0;
    end else begin
      // three stages also give a clean three-flop synchroniser on the pins
      in_q <= {in_q[pgc_pkg::PIPE_STAGES-2:0], {simplex_aligned_in, rerun_in}};
      out_q <= {out_q[pgc_pkg::PIPE_STAGES-2:0], status_raw};
    end
  end

  assign {tx_locked_out, tx_done_out, tx_fail_out, tx_busy_out, rx_locked_out, rx_aligned_out,
          rx_done_out, rx_fail_out, rx_busy_out} = out_q[pgc_pkg::PIPE_STAGES-1];

  // ----------------------------------------------------------------
  // checker
  // ----------------------------------------------------------------
  chk_if cbus ();

  assign cbus.rx_ena = rx_ena;
  assign cbus.rx_sop = rx_sop;
  assign cbus.rx_eop = rx_eop;
  assign cbus.rx_mty = rx_mty;
  assign cbus.rx_data = rx_data;
  assign cbus.rx_chan = rx_chan;
  assign cbus.rx_aligned = stat_rx_aligned;
  assign cbus.reset_done = reset_done;
  assign cbus.rerun_request_synced = rerun_request_synced;

  pkt_checker #(
    .NUM_PKTS(NUM_PKTS),
    .PKT_BEATS(PKT_BEATS)
  ) u_checker (
    .clk(clk),
    .rst_n(rst_n),
    .bus(cbus)
  );

  assign rx_err_data = cbus.err_data;
  assign rx_err_chan = cbus.err_chan;
  assign rx_err_mty = cbus.err_mty;

  // ----------------------------------------------------------------
  // generator state
  // ----------------------------------------------------------------
  pgc_pkg::gen_state_t state, next_state, ret_state, resume_state;
  logic [7:0] pkt_cnt;
  logic [7:0] beat_cnt;
  logic init_done;
  logic gen_busy;
  logic tx_done_int;
  logic tx_fail;
  logic gen_lock_seen;
  logic armed;

  // in hold the context is the transmit state that was left
  wire in_hold = (state == pgc_pkg::st_hold);
  wire in_send = (state == pgc_pkg::st_send_first) || (state == pgc_pkg::st_send_rest);
  wire in_first = in_hold ? (ret_state == pgc_pkg::st_send_first)
                          : (state == pgc_pkg::st_send_first);
  wire all_sent = (pkt_cnt == NUM_PKTS_C);
  wire load = tx_rdy && (in_send || in_hold);
  wire load_beat = load && !(in_first && all_sent);
  wire [7:0] beat_idx = in_first ? 8'h00 : beat_cnt;
  wire beat_last = in_first ? SINGLE_BEAT : (beat_cnt == LAST_BEAT_C);
  wire align_ok = SIMPLEX_TX ? remote_aligned : stat_rx_aligned;
  wire start_ok = reset_done && armed;
  wire both_idle = !gen_busy && !cbus.busy;

  always_comb begin
    if (in_first) begin
      if (all_sent) begin
        resume_state = pgc_pkg::st_done;
      end else begin
        resume_state = SINGLE_BEAT ? pgc_pkg::st_send_first : pgc_pkg::st_send_rest;
      end
    end else begin
      resume_state = beat_last ? pgc_pkg::st_send_first : pgc_pkg::st_send_rest;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      pgc_pkg::st_idle: if (start_ok) next_state = pgc_pkg::st_lock_setup;
      pgc_pkg::st_lock_setup: next_state = pgc_pkg::st_wait_align;
      pgc_pkg::st_wait_align: if (align_ok) next_state = pgc_pkg::st_enable_send;
      pgc_pkg::st_enable_send: next_state = pgc_pkg::st_tx_init;
      pgc_pkg::st_tx_init: if (init_done && tx_rdy) next_state = pgc_pkg::st_send_first;
      pgc_pkg::st_send_first,
      pgc_pkg::st_send_rest,
      pgc_pkg::st_hold: next_state = tx_rdy ? resume_state : pgc_pkg::st_hold;
      pgc_pkg::st_done: next_state = pgc_pkg::st_restart;
      pgc_pkg::st_restart: next_state = pgc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pgc_pkg::st_idle;
      ret_state <= pgc_pkg::st_send_first;
    end else begin
      state <= next_state;
      if (in_send && !tx_rdy) ret_state <= state;
    end
  end

  // ----------------------------------------------------------------
  // run control and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'h1;
      gen_busy <= 1'h0;
      tx_done_int <= 1'h0;
      gen_lock_seen <= 1'h0;
      init_done <= 1'h0;
    end else begin
      // a rerun is accepted only while neither side is busy
      if (state == pgc_pkg::st_idle && start_ok) begin
        armed <= 1'h0;
      end else if (rerun_request_synced && both_idle) begin
        armed <= 1'h1;
      end
      if (state == pgc_pkg::st_idle && start_ok) begin
        gen_busy <= 1'h1;
        tx_done_int <= 1'h0;
      end
      if (state == pgc_pkg::st_lock_setup) begin
        gen_lock_seen <= 1'h1;
        init_done <= 1'h0;
      end
      if (state == pgc_pkg::st_tx_init) init_done <= 1'h1;
      if (state == pgc_pkg::st_done) tx_done_int <= 1'h1;
      if (state == pgc_pkg::st_restart) gen_busy <= 1'h0;
    end
  end

  // overflow or underflow from the controller marks the run failed; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fail <= 1'h0;
    end else if (tx_ovf || tx_unf) begin
      tx_fail <= 1'h1;
    end else if (state == pgc_pkg::st_idle && start_ok) begin
      tx_fail <= 1'h0;
    end
  end

  assign status_raw = {gen_lock_seen, tx_done_int, tx_fail, gen_busy, cbus.checker_lock_seen,
                       stat_rx_aligned, cbus.report_done, cbus.failed, cbus.busy};

  // ----------------------------------------------------------------
  // controller configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_tx_enable <= pgc_pkg::TX_ENABLE_OFF;
      ctl_tx_mubits <= pgc_pkg::MUBITS_LOCK;
      ctl_tx_lanestat <= pgc_pkg::LANESTAT_LOCK;
      ctl_tx_intfstat <= pgc_pkg::INTFSTAT_LOCK;
    end else if (state == pgc_pkg::st_lock_setup) begin
      ctl_tx_enable <= pgc_pkg::TX_ENABLE_OFF;
      ctl_tx_mubits <= pgc_pkg::MUBITS_LOCK;
      ctl_tx_lanestat <= pgc_pkg::LANESTAT_LOCK;
      ctl_tx_intfstat <= pgc_pkg::INTFSTAT_LOCK;
    end else if (state == pgc_pkg::st_enable_send) begin
      ctl_tx_enable <= pgc_pkg::TX_ENABLE_ON;
    end
  end

  // ----------------------------------------------------------------
  // beat counters and bus control
  // ----------------------------------------------------------------
  // outside transmit init and restart, registers change only on load, so a stalled beat stays on the bus untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_cnt <= 8'h00;
      beat_cnt <= 8'h00;
      tx_ena <= 4'h0;
      tx_sop <= 4'h0;
      tx_eop <= 4'h0;
    end else if (state == pgc_pkg::st_tx_init || state == pgc_pkg::st_restart) begin
      pkt_cnt <= 8'h00;
      beat_cnt <= 8'h00;
      tx_ena <= 4'h0;
      tx_sop <= 4'h0;
      tx_eop <= 4'h0;
    end else if (load_beat) begin
      pkt_cnt <= beat_last ? pkt_cnt + 8'h01 : pkt_cnt;
      beat_cnt <= beat_last ? 8'h00 : beat_idx + 8'h01;
      tx_ena <= 4'hf;
      tx_sop <= {3'h0, in_first};
      tx_eop <= {beat_last, 3'h0};
    end else if (load) begin
      tx_ena <= 4'h0;
      tx_sop <= 4'h0;
      tx_eop <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // segment payload
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < pgc_pkg::SEGS; s++) begin : g_seg
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_data[s*pgc_pkg::SEG_W +: pgc_pkg::SEG_W] <= '0;
          tx_chan[s*pgc_pkg::CH_W +: pgc_pkg::CH_W] <= '0;
          tx_mty[s*pgc_pkg::MTY_W +: pgc_pkg::MTY_W] <= '0;
        end else if (load_beat) begin
          tx_data[s*pgc_pkg::SEG_W +: pgc_pkg::SEG_W] <=
            pgc_pkg::exp_data(pkt_cnt, beat_idx, 2'(s));
          tx_chan[s*pgc_pkg::CH_W +: pgc_pkg::CH_W] <= pgc_pkg::exp_chan(pkt_cnt);
          // all beats are full, so no empty bytes are ever reported
          tx_mty[s*pgc_pkg::MTY_W +: pgc_pkg::MTY_W] <= 4'h0;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sim/pgc_properties.sv
// Purpose: port assertions for pkt_gen_check
// Assumes: one clock, rst_n async low
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module pgc_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stat_rx_aligned,
  input wire logic tx_rdy,
  input wire logic ctl_tx_enable,
  input wire logic ctl_tx_intfstat,
  input wire logic tx_done_out,
  input wire logic rx_aligned_out,
  input wire logic [7:0] ctl_tx_mubits,
  input wire logic [11:0] ctl_tx_lanestat,
  input wire logic [3:0] tx_ena,
  input wire logic [3:0] tx_sop,
  input wire logic [3:0] rx_ena,
  input wire logic [3:0] rx_err_data,
  input wire logic [15:0] tx_mty,
  input wire logic [511:0] tx_data
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_CTL_FIXED: assert property (
    ctl_tx_mubits == 8'h00 && ctl_tx_lanestat == 12'hfff && ctl_tx_intfstat)
    else $error("fixed controls wrong");
  AST_EN_FIRST: assert property (|tx_ena |-> ctl_tx_enable)
    else $error("beat before enable");
  AST_EN_ALIGN: assert property ($rose(ctl_tx_enable) |-> $past(stat_rx_aligned, 2))
    else $error("enable without align");
  AST_HOLD: assert property (|tx_ena && !tx_rdy |=> $stable(tx_data) && $stable(tx_ena))
    else $error("beat changed in stall");
  AST_BEAT_FORM: assert property (
    |tx_ena |-> tx_ena == 4'hf && tx_mty == 16'h0000 && tx_sop[3:1] == 3'h0)
    else $error("bad beat form");
  AST_ALIGN_STAGE: assert property (rx_aligned_out == $past(stat_rx_aligned, 3))
    else $error("align out not staged");
  AST_ERR_BEAT: assert property (|rx_err_data |-> |$past(rx_ena))
    else $error("error without beat");
  AST_DONE_QUIET: assert property (tx_done_out |-> tx_ena == 4'h0)
    else $error("beat after done");
endmodule
bind pkt_gen_check pgc_properties u_props (.clk, .rst_n, .stat_rx_aligned, .tx_rdy,
  .ctl_tx_enable, .ctl_tx_intfstat, .tx_done_out, .rx_aligned_out, .ctl_tx_mubits,
  .ctl_tx_lanestat, .tx_ena, .tx_sop, .rx_ena, .rx_err_data, .tx_mty, .tx_data);
`default_nettype wire

// >>> sim/ctrl_model.sv
// Purpose: controller stand-in looping the tx bus to rx
// Assumes: clk shared
// Notes: idle rx data is inverted so a stale beat never matches
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic bad,
  input wire logic [3:0] tx_ena,
  input wire logic [3:0] tx_sop,
  input wire logic [3:0] tx_eop,
  input wire logic [15:0] tx_mty,
  input wire logic [511:0] tx_data,
  input wire logic [43:0] tx_chan,
  output logic tx_rdy,
  output logic [3:0] rx_ena,
  output logic [3:0] rx_sop,
  output logic [3:0] rx_eop,
  output logic [15:0] rx_mty,
  output logic [511:0] rx_data,
  output logic [43:0] rx_chan
);
  logic [1:0] cnt;
  wire logic take = |tx_ena && tx_rdy;
  assign tx_rdy = !(slow && cnt == 2'h3);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      rx_ena <= 4'h0;
    end else begin
      cnt <= cnt + 2'h1;
      rx_ena <= take ? tx_ena : 4'h0;
    end
  end
  // bad flips seg0 data bit 0, seg1 channel bit 0 and the top bit of the seg3 empty count
  always_ff @(posedge clk) begin
    rx_sop <= tx_sop;
    rx_eop <= take ? tx_eop : 4'h0;
    rx_mty <= tx_mty ^ {bad, 15'h0000};
    rx_chan <= tx_chan ^ {32'h0000_0000, bad, 11'h000};
    rx_data <= take ? tx_data ^ {511'h0, bad} : ~rx_data;
  end
endmodule
`default_nettype wire

// >>> sim/pkt_gen_check_tb.sv
// Purpose: self-checking bench for pkt_gen_check
// Assumes: loopback partner, runs of two packets of two beats
// Notes: partner stalls ready every fourth cycle when slow
`timescale 1ns/1ps
`default_nettype none
module pkt_gen_check_tb;
  logic clk, rst_n, reset_done, stat_rx_aligned, rerun_in, tx_rdy, slow, bad;
  logic ctl_tx_enable, ctl_tx_intfstat, tx_locked_out, tx_done_out, tx_fail_out, tx_busy_out;
  logic rx_locked_out, rx_aligned_out, rx_done_out, rx_fail_out, rx_busy_out, rx_err_mty;
  logic [7:0] ctl_tx_mubits;
  logic [8:0] errs;
  logic [11:0] ctl_tx_lanestat;
  logic [3:0] tx_ena, tx_sop, tx_eop, rx_ena, rx_sop, rx_eop, rx_err_data, rx_err_chan;
  logic [15:0] tx_mty, rx_mty;
  logic [511:0] tx_data, rx_data;
  logic [43:0] tx_chan, rx_chan;
  int n_fail, checks, beats, i;
  pkt_gen_check #(.NUM_PKTS(2), .PKT_BEATS(2)) u_dut (.clk, .rst_n, .reset_done,
    .stat_rx_aligned, .rerun_in, .simplex_aligned_in(1'b0), .tx_rdy, .tx_ovf(1'b0),
    .tx_unf(1'b0), .ctl_tx_enable, .ctl_tx_mubits, .ctl_tx_lanestat, .ctl_tx_intfstat, .tx_ena,
    .tx_sop, .tx_eop, .tx_mty, .tx_data, .tx_chan, .rx_ena, .rx_sop, .rx_eop, .rx_mty, .rx_data,
    .rx_chan, .tx_locked_out, .tx_done_out, .tx_fail_out, .tx_busy_out, .rx_locked_out,
    .rx_aligned_out, .rx_done_out, .rx_fail_out, .rx_busy_out, .rx_err_data, .rx_err_chan,
    .rx_err_mty);
  ctrl_model u_far (.clk, .rst_n, .slow, .bad, .tx_ena, .tx_sop, .tx_eop, .tx_mty, .tx_data,
    .tx_chan, .tx_rdy, .rx_ena, .rx_sop, .rx_eop, .rx_mty, .rx_data, .rx_chan);
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_start();
    tick(10);
    chk("locked early", tx_locked_out, 1'h0);
    reset_done = 1;
    tick(20);
    chk("enable", ctl_tx_enable, 1'h0);
    chk("rx locked", rx_locked_out, 1'h1);
    stat_rx_aligned = 1;
    for (i = 0; i < 100 && !(|tx_ena); i++) tick(1);
    chk("enable", ctl_tx_enable, 1'h1);
    chk("seg3 byte", tx_data[391:384], 8'h03);
  endtask
  task automatic t_run(input logic first, input logic b, input logic exp_fail);
    bad = b;
    if (!first) begin
      beats = 0;
      errs = 9'h000;
      // a reconfiguration access costs alignment; traffic must wait for realign
      stat_rx_aligned = 0;
      rerun_in = 1;
      for (i = 0; i < 200 && rx_done_out; i++) tick(1);
      rerun_in = 0;
      tick(2);
      chk("align wait", ctl_tx_enable, 1'h0);
      chk("rx aligned out", rx_aligned_out, 1'h0);
      stat_rx_aligned = 1;
    end
    for (i = 0; i < 3000 && !rx_done_out; i++) tick(1);
    tick(5);
    chk("rx done", rx_done_out, 1'h1);
    chk("beats", beats, 32'h0000_0004);
    chk("tx done", tx_done_out, 1'h1);
    chk("tx busy", tx_busy_out, 1'h0);
    chk("rx busy", rx_busy_out, 1'h0);
    chk("rx fail", rx_fail_out, exp_fail);
    chk("errors", errs, b ? 9'h121 : 9'h000);
  endtask
  always @(posedge clk) begin
    if (|tx_ena && tx_rdy) beats++;
    errs <= errs | {rx_err_mty, rx_err_chan, rx_err_data};
  end
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {rst_n, reset_done, stat_rx_aligned, rerun_in, slow, bad} = 6'h00;
    {n_fail, checks, beats} = 0;
    errs = 9'h000;
    tick(12);
    rst_n = 1;
    t_start();
    t_run(1, 0, 0);
    slow = 1;
    t_run(0, 1, 1);
    t_run(0, 0, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
